// [core/mcpi_pkg.sv]
package mcpi_pkg;
	// Clock rate and timing figures.
	localparam int CLK_MHZ = 10;
	localparam int T_CNTL_US = 100;
	localparam int T_LPEXIT_S = 60;
	localparam int T_TXON_MS = 5;
	localparam int T_INIT_MS = 2500;
	// Filter window is half the control pulse width, so the transmit shutdown stays fast.
	localparam logic [9:0] FILT_CYC = 10'(T_CNTL_US * CLK_MHZ / 2);
	localparam int LPEXIT_CYC = T_LPEXIT_S * CLK_MHZ * 1000000;
	localparam int TXON_CYC = T_TXON_MS * CLK_MHZ * 1000;
	localparam int INIT_CYC = T_INIT_MS * CLK_MHZ * 1000;
	localparam logic [31:0] INIT_WAIT = 32'(2 * FILT_CYC);
	// Filtered pin indices.
	localparam int P_LP = 0;
	localparam int P_TXOFF = 1;
	localparam int P_C1 = 2;
	localparam int P_C2 = 3;
	localparam int P_C3 = 4;
	localparam logic [4:0] FILT_RST = 5'h1F;
	// Register addresses and bit positions.
	localparam logic [15:0] A_PCLASS = 16'h8001;
	localparam logic [15:0] A_LPEXIT = 16'h8072;
	localparam logic [15:0] A_TXON = 16'h8073;
	localparam logic [15:0] A_EXACT = 16'h807E;
	localparam logic [15:0] A_FSEL1 = 16'hA005;
	localparam logic [15:0] A_FSEL2 = 16'hA006;
	localparam logic [15:0] A_FSEL3 = 16'hA007;
	localparam logic [15:0] A_CTRL = 16'hA010;
	localparam logic [15:0] A_LOSLAT = 16'hA018;
	localparam logic [15:0] A_GSTAT = 16'hA01D;
	localparam int B_SRST = 10;
	localparam int B_SLP = 8;
	localparam int B_PIN1 = 1;
	localparam int B_IL = 13;
	localparam logic [15:0] FSEL_DEF = 16'h0000;
	localparam logic [5:0] PRE_LEN = 6'h20;
	// Management frame opcodes.
	localparam logic [1:0] OP_ADDR = 2'h0;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [1:0] OP_RINC = 2'h2;
	localparam logic [1:0] OP_RD = 2'h3;
	typedef enum logic [2:0] {
		ST_INIT = 3'h1, ST_LOWPWR = 3'h2, ST_HPUP = 3'h3, ST_READY = 3'h4
	} mcpi_mst_t;
	typedef enum logic [1:0] {
		MI_IDLE = 2'h0, MI_HDR = 2'h1, MI_TA = 2'h2, MI_DATA = 2'h3
	} mcpi_mi_t;
	typedef struct packed {
		mcpi_mst_t       mst;
		logic [31:0]     cnt;
		logic [31:0]     txcnt;
		logic [1:0]      il_code;
		logic            il_stat;
		logic [4:0]      filt;
		logic [4:0][9:0] fcnt;
		logic            lp_soft;
		logic            rst_soft;
		logic [15:0]     fsel1;
		logic [15:0]     fsel2;
		logic [15:0]     fsel3;
		logic [3:0]      loslat;
		logic            xrst_n;
		logic [3:0]      tx_en;
		logic            los_pin;
		logic            galrm_n;
		logic            hipwr;
		mcpi_mi_t        mi;
		logic            mdc_q;
		logic [5:0]      bcnt;
		logic [15:0]     sr;
		logic [1:0]      op;
		logic            hit;
		logic [15:0]     addr;
		logic            mdio_o;
		logic            mdio_oe_n;
	} mcpi_state_t;
endpackage : mcpi_pkg

// [core/mcpi_core.sv]
`timescale 1ns/1ps
// Overview of operation
// - Enter low power within 1 ms; exit within 60 s, bound readable.
// - Signal-lost output asserts within 100 us of optical loss.
// - Signal-lost output deasserts within 100 us of optical return.
// - Global alarm is the OR of alarm bits, following within 150 ms.
// - Initialization completes within 2.5 s after reset release.
// - Transmit-off pin shuts all transmitter lanes within 100 us.
// - Transmitter turns on within 5 ms of transmit-off release, bound readable.
// - Management bus serves nonvolatile and volatile register pages.
// - IC reset released only when control-1 pin high (or fsel1 not default) and soft reset clear.
// - Control-1 pin level is mirrored into the module control register.
// - Interlock pins encode host cooling class, high bit first.
// - Interlock status is 0 for code 11 or fitting power, else 1.
// - Interlock pins sampled exactly once during initialization and stored.
// - On low-power release, stored code is compared with designed class.
// - Interlock status 1 keeps low power; 0 allows high-power start-up.
// - After init, control-1 pin meaning follows its function-select register; fsel2 and fsel3 are only stored.
// - Loss of signal is detected separately per optical lane.
// - Transmit-off high disables all lanes; low enables them only in the ready state.
// - Low-power pin high keeps low power; low allows power-on.
// - Signal-lost output high for low optical input, low otherwise.
// - Active-low global alarm is low whenever an alarm bit is set.
module mcpi_core import mcpi_pkg::*; #(
	parameter int          HIPWR_WAIT = LPEXIT_CYC - int'(FILT_CYC) - 8,
	parameter int          TXON_WAIT  = TXON_CYC - int'(FILT_CYC) - 8,
	parameter logic [4:0]  DEVAD      = 5'h01,
	parameter logic [1:0]  MOD_CLASS  = 2'h2,
	parameter logic [15:0] EXACT_PWR  = 16'h005A
) (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       resetn,
	// Control pins from the host.
	input  wire logic       low_power_request,
	input  wire logic       transmit_off,
	input  wire logic       prog_control_one,
	input  wire logic       prog_control_two,
	input  wire logic       prog_control_three,
	// Per-lane optical signal detectors.
	input  wire logic [3:0] optical_low,
	// Management interface.
	input  wire logic       mdc,
	input  wire logic       mdio_in,
	output logic            mdio_out,
	output logic            mdio_oe_n,
	input  wire logic [2:0] port_addr,
	// Status and control outputs.
	output logic            rx_signal_lost,
	output logic            global_alarm_n,
	output logic            transceiver_ic_reset_n,
	output logic [3:0]      tx_lane_enable,
	output logic            high_power_on
);
	mcpi_state_t q;
	mcpi_state_t d;
	logic [1:0]  rs_q;
	logic        rst_n;
	logic [4:0]  raw;
	logic        lp_req;
	logic        pin1_eff;
	logic        rise;
	logic [15:0] nsr;
	logic [3:0]  clr;
	logic        il_new;

	// Reset release goes through two flip-flops.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rs_q <= 2'h0;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end
	assign rst_n = rs_q[1];

	// Read multiplexer over both register pages.
	function automatic logic [15:0] rd(input mcpi_state_t s, input logic [15:0] a);
		logic [15:0] v;
		v = 16'h0000;
		case (a)
			A_PCLASS: v[7:6] = MOD_CLASS;
			A_LPEXIT: v = 16'(T_LPEXIT_S);
			A_TXON:   v = 16'(T_TXON_MS);
			A_EXACT:  v = EXACT_PWR;
			A_FSEL1:  v = s.fsel1;
			A_FSEL2:  v = s.fsel2;
			A_FSEL3:  v = s.fsel3;
			A_CTRL: begin
				v[B_SRST] = s.rst_soft;
				v[B_SLP] = s.lp_soft;
				v[B_PIN1] = s.filt[P_C1];
			end
			A_LOSLAT: v[3:0] = s.loslat;
			A_GSTAT: begin
				v[B_IL] = s.il_stat;
				v[2:0] = s.mst;
			end
			default:  v = 16'h0000;
		endcase
		return v;
	endfunction : rd

	// Raw pins in filter order, plus the request, pin-1 and clock-edge terms built from state.
	assign raw = {prog_control_three, prog_control_two, prog_control_one, transmit_off, low_power_request};
	assign lp_req = q.filt[P_LP] | q.lp_soft;
	assign pin1_eff = (q.fsel1 == FSEL_DEF) ? q.filt[P_C1] : 1'b1;
	assign rise = mdc & ~q.mdc_q;
	assign nsr = {q.sr[14:0], mdio_in};
	assign il_new = (q.il_code != 2'h3) && (MOD_CLASS > q.il_code);

	// Next-state logic for the whole block.
	always_comb begin
		d = q;
		clr = 4'h0;
		// Pin filters accept a level only after it has stood a full window.
		for (int i = 0; i < 5; i++) begin
			if (raw[i] == q.filt[i]) begin
				d.fcnt[i] = 10'h000;
			end else if (q.fcnt[i] == FILT_CYC - 10'h001) begin
				d.filt[i] = raw[i];
				d.fcnt[i] = 10'h000;
			end else begin
				d.fcnt[i] = q.fcnt[i] + 10'h001;
			end
		end
		// Power sequence.
		d.cnt = q.cnt + 32'h1;
		case (q.mst)
			ST_INIT: begin
				if (q.cnt >= INIT_WAIT) begin
					d.il_code = {q.filt[P_C3], q.filt[P_C2]};
					d.mst = ST_LOWPWR;
					d.cnt = 32'h0;
				end
			end
			ST_LOWPWR: begin
				d.cnt = 32'h0;
				if (!lp_req) begin
					d.il_stat = il_new;
					if (!il_new) begin
						d.mst = ST_HPUP;
					end
				end
			end
			// High-power start-up runs its wait unless a low-power request comes back.
			ST_HPUP: begin
				if (lp_req) begin
					d.mst = ST_LOWPWR;
				end else if (q.cnt >= 32'(HIPWR_WAIT)) begin
					d.mst = ST_READY;
				end
			end
			ST_READY: begin
				if (lp_req) begin
					d.mst = ST_LOWPWR;
				end
			end
			default: d.mst = ST_INIT;
		endcase
		d.hipwr = (d.mst == ST_READY);
		// Transceiver IC reset from pin, soft bit and sequence state.
		d.xrst_n = (q.mst != ST_INIT) && pin1_eff && !q.rst_soft;
		// Transmitter lanes: off at once, on after the turn-on delay.
		if (q.filt[P_TXOFF] || q.mst != ST_READY) begin
			d.tx_en = 4'h0;
			d.txcnt = 32'h0;
		end else if (q.txcnt >= 32'(TXON_WAIT)) begin
			d.tx_en = 4'hF;
		end else begin
			d.txcnt = q.txcnt + 32'h1;
		end
		// Management serial slave, sampled on rising clock edges.
		d.mdc_q = mdc;
		if (rise) begin
			case (q.mi)
				// Preamble: a run of 32 ones arms the header on the next zero.
				MI_IDLE: begin
					if (mdio_in) begin
						d.bcnt = (q.bcnt == PRE_LEN) ? q.bcnt : q.bcnt + 6'h01;
					end else if (q.bcnt == PRE_LEN) begin
						d.mi = MI_HDR;
						d.sr = 16'h0000;
						d.bcnt = 6'h01;
					end else begin
						d.bcnt = 6'h00;
					end
				end
				// Header: start bits, opcode and both addresses, MSB first.
				MI_HDR: begin
					d.sr = nsr;
					d.bcnt = q.bcnt + 6'h01;
					if (q.bcnt == 6'h0D) begin
						d.op = nsr[11:10];
						d.hit = (nsr[13:12] == 2'h0) && (nsr[9:5] == {2'h0, port_addr}) && (nsr[4:0] == DEVAD);
						d.mi = MI_TA;
						d.bcnt = 6'h00;
					end
				end
				// Turnaround: a read loads the word and starts to drive the line.
				MI_TA: begin
					d.bcnt = q.bcnt + 6'h01;
					if (q.hit && q.op[1]) begin
						if (q.bcnt == 6'h00) begin
							d.mdio_oe_n = 1'b0;
							d.mdio_o = 1'b0;
							d.sr = rd(q, q.addr);
						end else begin
							d.mdio_o = q.sr[15];
							d.sr = {q.sr[14:0], 1'b0};
						end
					end
					if (q.bcnt == 6'h01) begin
						d.mi = MI_DATA;
						d.bcnt = 6'h00;
					end
				end
				// Data: shift out on reads, shift in on writes and address frames.
				MI_DATA: begin
					d.bcnt = q.bcnt + 6'h01;
					if (q.hit && q.op[1]) begin
						d.mdio_o = q.sr[15];
						d.sr = {q.sr[14:0], 1'b0};
					end else begin
						d.sr = nsr;
					end
					if (q.bcnt == 6'h0F) begin
						d.mi = MI_IDLE;
						d.bcnt = 6'h00;
						d.mdio_oe_n = 1'b1;
						d.mdio_o = 1'b0;
						// Only frames addressed to this port touch the registers.
						if (q.hit) begin
							case (q.op)
								OP_ADDR: d.addr = nsr;
								OP_RINC: d.addr = q.addr + 16'h0001;
								OP_WR: begin
									case (q.addr)
										A_FSEL1: d.fsel1 = nsr;
										A_FSEL2: d.fsel2 = nsr;
										A_FSEL3: d.fsel3 = nsr;
										A_CTRL: begin
											d.rst_soft = nsr[B_SRST];
											d.lp_soft = nsr[B_SLP];
										end
										A_LOSLAT: clr = nsr[3:0];
										default: d.addr = q.addr;
									endcase
								end
								default: d.addr = q.addr;
							endcase
						end
					end
				end
				default: d.mi = MI_IDLE;
			endcase
		end
		// Per-lane loss latches; a new loss beats a clear in the same cycle.
		d.loslat = (q.loslat & ~clr) | optical_low;
		d.los_pin = |optical_low;
		d.galrm_n = ~(|q.loslat);
	end

	// State register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.mst <= ST_INIT;
			q.filt <= FILT_RST;
			q.fsel1 <= FSEL_DEF;
			q.fsel2 <= FSEL_DEF;
			q.fsel3 <= FSEL_DEF;
			q.galrm_n <= 1'b1;
			q.mdio_oe_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Every output comes straight from a state flip-flop.
	assign mdio_out = q.mdio_o;
	assign mdio_oe_n = q.mdio_oe_n;
	assign rx_signal_lost = q.los_pin;
	assign global_alarm_n = q.galrm_n;
	assign transceiver_ic_reset_n = q.xrst_n;
	assign tx_lane_enable = q.tx_en;
	assign high_power_on = q.hipwr;

	// Checks on the sequencing and pin behaviour.
	a_tx_off_lanes: assert property (@(posedge clk) disable iff (!rst_n)
		q.filt[P_TXOFF] |=> (tx_lane_enable == 4'h0)) else $error("lanes on while transmit off");
	a_txon_delay: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(tx_lane_enable[0]) |-> (q.txcnt >= 32'(TXON_WAIT))) else $error("transmitter on too early");
	a_pin_reset: assert property (@(posedge clk) disable iff (!rst_n)
		(!q.filt[P_C1] && q.fsel1 == FSEL_DEF) || q.rst_soft |=> !transceiver_ic_reset_n)
		else $error("ic reset not held");
	a_los_follow: assert property (@(posedge clk) disable iff (!rst_n)
		(|optical_low) |=> rx_signal_lost ##0 q.loslat != 4'h0) else $error("signal lost not raised");
	a_los_clear: assert property (@(posedge clk) disable iff (!rst_n)
		!(|optical_low) |=> !rx_signal_lost) else $error("signal lost not released");
	a_alarm_or: assert property (@(posedge clk) disable iff (!rst_n)
		(|q.loslat) |=> !global_alarm_n) else $error("alarm output not low");
	a_il_sample: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(q.il_code) |-> $past(q.mst) == ST_INIT && q.mst == ST_LOWPWR)
		else $error("interlock code resampled");
	a_il_code11: assert property (@(posedge clk) disable iff (!rst_n)
		q.mst == ST_LOWPWR && !lp_req && q.il_code == 2'h3 |=> !q.il_stat && q.mst == ST_HPUP)
		else $error("interlock wrong for top class");
	a_lp_hold: assert property (@(posedge clk) disable iff (!rst_n)
		q.mst == ST_LOWPWR && lp_req |=> q.mst == ST_LOWPWR) else $error("left low power");
	a_lp_entry: assert property (@(posedge clk) disable iff (!rst_n)
		(q.mst == ST_HPUP || q.mst == ST_READY) && lp_req |=> q.mst == ST_LOWPWR ##1 !high_power_on)
		else $error("low power not entered");
	a_il_block: assert property (@(posedge clk) disable iff (!rst_n)
		q.mst == ST_LOWPWR && !lp_req && il_new |=> q.mst == ST_LOWPWR ##0 q.il_stat)
		else $error("start-up despite interlock");

	// Checks on the management slave, the lanes, the IC reset, the global alarm and the interlock record.
	a_mdio_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		(q.mi == MI_IDLE || q.mi == MI_HDR) |-> mdio_oe_n)
		else $error("management line driven outside a read");
	a_lanes_ready: assert property (@(posedge clk) disable iff (!rst_n)
		tx_lane_enable != 4'h0 |-> tx_lane_enable == 4'hF && $past(!q.filt[P_TXOFF] && q.mst == ST_READY))
		else $error("lanes on outside ready");
	a_init_reset: assert property (@(posedge clk) disable iff (!rst_n)
		q.mst == ST_INIT |=> !transceiver_ic_reset_n)
		else $error("ic reset released during initialization");
	a_ic_release: assert property (@(posedge clk) disable iff (!rst_n)
		transceiver_ic_reset_n |-> $past(pin1_eff && !q.rst_soft && q.mst != ST_INIT))
		else $error("ic reset released without pin and soft bit");
	a_alarm_clear: assert property (@(posedge clk) disable iff (!rst_n)
		!(|q.loslat) |=> global_alarm_n)
		else $error("alarm output low without alarm");
	a_ready_clear: assert property (@(posedge clk) disable iff (!rst_n)
		high_power_on |-> !q.il_stat)
		else $error("high power with interlock set");
	a_class_sample: assert property (@(posedge clk) disable iff (!rst_n)
		$past(q.mst) == ST_INIT && q.mst == ST_LOWPWR |-> q.il_code == $past({q.filt[P_C3], q.filt[P_C2]}))
		else $error("interlock code not taken from the pins");
endmodule : mcpi_core

// [tb/mcpi_host.sv]
`timescale 1ns/1ps
// Host board model: runs the management clock and line and hands back each read word.
module mcpi_host #(
	parameter logic [4:0] PRTAD = 5'h05,
	parameter logic [4:0] DEVAD = 5'h01
) (
	input  wire logic  clk,
	input  wire logic  mdio_w,
	output logic       mdc,
	output logic       host_oe,
	output logic       host_bit,
	output logic       rd_valid,
	output logic [15:0] rd_data
);
	// Idle levels before any frame.
	initial begin
		mdc = 1'b0;
		host_oe = 1'b0;
		host_bit = 1'b1;
		rd_valid = 1'b0;
		rd_data = 16'h0000;
	end
	// One bit of 300 ns: low for 200 ns, then high for 100 ns, slower than 4 MHz.
	task automatic mbit(input logic oe, input logic b, output logic seen);
		@(negedge clk);
		mdc = 1'b0;
		host_oe = oe;
		host_bit = b;
		repeat (2) @(negedge clk);
		seen = mdio_w;
		mdc = 1'b1;
	endtask : mbit
	// A whole frame with a fresh preamble; read frames release the line from turnaround on.
	task automatic frame(input logic [1:0] op, input logic [15:0] data);
		logic        s;
		logic [13:0] hdr;
		hdr = {2'h0, op, PRTAD, DEVAD};
		for (int i = 0; i < 32; i++)
			mbit(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--)
			mbit(1'b1, hdr[i], s);
		for (int j = 1; j <= 18; j++) begin
			mbit(~op[1], (j == 1) ? 1'b1 : ((j == 2) ? 1'b0 : data[18 - j]), s);
			if (j >= 3)
				rd_data[18 - j] = s;
		end
		@(negedge clk);
		mdc = 1'b0;
		host_oe = 1'b0;
		rd_valid = op[1];
		@(negedge clk);
		rd_valid = 1'b0;
	endtask : frame
	// Register access: an address frame, then the data frame.
	task automatic acc(input logic [1:0] op, input logic [15:0] addr, input logic [15:0] data);
		frame(2'h0, addr);
		frame(op, data);
	endtask : acc
endmodule : mcpi_host

// [tb/module_control_power_interlock_tb.sv]
`timescale 1ns/1ps
// Bench: pin stimulus, host model, expectation queue and verdict.
module module_control_power_interlock_tb import mcpi_pkg::*;;
	localparam int HOLD = 1100; // Each pin level stands longer than 100 us.
	logic        clk = 1'b0;
	logic        resetn, lp, txoff, c1, c2, c3, snap;
	logic [3:0]  opt, tle, m;
	logic        mdc, mdio_out, mdio_oe_n, host_oe, host_bit, mdio_w;
	logic        rsl, gan, trn, hpo, rd_valid;
	logic [15:0] rd_data, pins, r;
	logic [15:0] exp_q[$];
	int          err_count = 0;
	int          compares = 0;
	int          cyc = 0;
	// Clock of 100 ns and the wire level from both drivers, pulled up when released.
	always #50 clk = ~clk;
	assign mdio_w = !mdio_oe_n ? mdio_out : (host_oe ? host_bit : 1'b1);
	assign pins = {8'h00, rsl, gan, trn, hpo, tle};
	mcpi_core #(.HIPWR_WAIT(50), .TXON_WAIT(20)) i_dut (.clk(clk), .resetn(resetn),
		.low_power_request(lp), .transmit_off(txoff), .prog_control_one(c1),
		.prog_control_two(c2), .prog_control_three(c3), .optical_low(opt), .mdc(mdc),
		.mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .port_addr(3'h5),
		.rx_signal_lost(rsl), .global_alarm_n(gan), .transceiver_ic_reset_n(trn),
		.tx_lane_enable(tle), .high_power_on(hpo));
	mcpi_host i_host (.clk(clk), .mdio_w(mdio_w), .mdc(mdc), .host_oe(host_oe),
		.host_bit(host_bit), .rd_valid(rd_valid), .rd_data(rd_data));
	// Compares one result with its expectation.
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		compares++;
		if (seen !== want) begin
			err_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask : check
	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// Each read word or pin snapshot takes the oldest expectation off the queue.
	always @(posedge clk) begin
		if (rd_valid === 1'b1 || snap === 1'b1)
			check(rd_valid === 1'b1 ? rd_data : pins, exp_q.size() != 0 ? exp_q.pop_front() : 16'hDEAD);
	end
	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			print_verdict();
		end
	end
	// Notes a pin snapshot and raises the snapshot strobe for one cycle.
	task automatic pin_exp(input logic [15:0] want);
		exp_q.push_back(want);
		@(negedge clk);
		snap = 1'b1;
		@(negedge clk);
		snap = 1'b0;
	endtask : pin_exp
	// Notes the expected word, then reads it through the host model.
	task automatic rd(input logic [15:0] a, input logic [15:0] want);
		exp_q.push_back(want);
		i_host.acc(OP_RD, a, 16'h0000);
	endtask : rd
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		i_host.acc(OP_WR, a, d);
	endtask : wr
	task automatic hold();
		repeat (HOLD) @(negedge clk);
	endtask : hold
	// Reset with an interlock code kept stable through initialization.
	task automatic rst(input logic hi, input logic lo);
		@(negedge clk);
		resetn = 1'b0;
		c3 = hi;
		c2 = lo;
		lp = 1'b1;
		repeat (3) @(negedge clk);
		pin_exp(16'h0040);
		resetn = 1'b1;
		hold();
	endtask : rst
	// Main sequence.
	initial begin
		logic [15:0] ta[6];
		logic [15:0] tv[6];
		ta = '{A_PCLASS, A_LPEXIT, A_TXON, A_EXACT, A_GSTAT, 16'h8100};
		tv = '{16'h0080, 16'h003C, 16'h0005, 16'h005A, 16'h0002, 16'h0000};
		{resetn, lp, txoff, c1, c2, c3, snap, opt} = {7'b0111010, 4'h0};
		void'($urandom(32'h80AA));
		rst(1'b1, 1'b0);
		for (int i = 0; i < 6; i++)
			rd(ta[i], tv[i]);
		r = 16'($urandom());
		wr(A_FSEL2, r);
		rd(A_FSEL2, r);
		wr(A_FSEL2, FSEL_DEF);
		$display("test registers done");
		lp = 1'b0;
		txoff = 1'b0;
		hold();
		pin_exp(16'h007F);
		rd(A_GSTAT, 16'h0004);
		rd(A_CTRL, 16'h0002);
		$display("test power up done");
		wr(A_CTRL, 16'h0400);
		pin_exp(16'h005F);
		rd(A_CTRL, 16'h0402);
		wr(A_CTRL, 16'h0000);
		c1 = 1'b0;
		hold();
		pin_exp(16'h005F);
		rd(A_CTRL, 16'h0000);
		wr(A_FSEL1, 16'h0001);
		pin_exp(16'h007F);
		wr(A_FSEL1, FSEL_DEF);
		pin_exp(16'h005F);
		c1 = 1'b1;
		hold();
		pin_exp(16'h007F);
		$display("test reset control done");
		txoff = 1'b1;
		repeat (998) @(negedge clk);
		pin_exp(16'h0070);
		txoff = 1'b0;
		hold();
		pin_exp(16'h007F);
		$display("test transmit off done");
		m = 4'($urandom_range(15, 1));
		opt = m;
		repeat (10) @(negedge clk);
		pin_exp(16'h00BF);
		rd(A_LOSLAT, {12'h000, m});
		opt = 4'h0;
		repeat (10) @(negedge clk);
		pin_exp(16'h003F);
		wr(A_LOSLAT, {12'h000, m});
		pin_exp(16'h007F);
		rd(A_LOSLAT, 16'h0000);
		$display("test signal loss done");
		wr(A_CTRL, 16'h0100);
		pin_exp(16'h0060);
		rd(A_CTRL, 16'h0102);
		wr(A_CTRL, 16'h0000);
		lp = 1'b1;
		hold();
		pin_exp(16'h0060);
		rd(A_GSTAT, 16'h0002);
		$display("test low power done");
		rst(1'b0, 1'b0);
		{c3, c2} = 2'h3;
		hold();
		lp = 1'b0;
		hold();
		rd(A_GSTAT, 16'h2002);
		rst(1'b1, 1'b1);
		lp = 1'b0;
		hold();
		rd(A_GSTAT, 16'h0004);
		$display("test interlock done");
		print_verdict();
	end
endmodule : module_control_power_interlock_tb
